/* File: rhb_pkg.sv */
// Purpose: shared constants and types for the resonant half-bridge mode controller
// Assumes: 50 MHz core clock, 10-bit threshold and feedback codes (1 code = 1 uA on feedback)
// Notes: gate and rate limits are kept in ns or Hz and their cycle counts derived; pacing steps are given in cycles
package rhb_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int DAC_W = 10;
  localparam int TMR_W = 16;
  localparam int LP_W = 12;
  localparam int TIMER_W = 18;
  localparam int BURST_N_W = 8;
  localparam int SYNC_W = 7;

  // gate timing limits (plain defaults)
  localparam int TON_MIN_NS = 1000;
  localparam int TON_MAX_NS = 25000;
  localparam int TNO_MIN_NS = 200;
  localparam int TNO_MAX_NS = 1000;
  // least times round up, longest times round down
  localparam logic [TMR_W-1:0] TON_MIN_CYC =
    TMR_W'((TON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] TON_MAX_CYC = TMR_W'(TON_MAX_NS / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] TNO_MIN_CYC =
    TMR_W'((TNO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] TNO_MAX_CYC = TMR_W'(TNO_MAX_NS / CLK_PERIOD_NS);

  // low-power cycle may not stretch below the minimum low-power frequency
  localparam int MIN_LOW_POWER_FREQUENCY_HZ = 23_000;
  localparam logic [LP_W-1:0] LP_PERIOD_MAX_CYC =
    LP_W'(CLK_FREQ_HZ / MIN_LOW_POWER_FREQUENCY_HZ);
  localparam logic [LP_W-1:0] HOLD_STEP = 12'h010;
  localparam logic [1:0] LP_HALF_LAST = 2'h2;

  // slowest burst rate; faster rates are this period shifted right by the select
  localparam int BURST_FREQ_MIN_HZ = 200;
  localparam int BURST_200HZ_CYCLES = CLK_FREQ_HZ / BURST_FREQ_MIN_HZ;
  localparam logic [BURST_N_W-1:0] BURST_N_INIT = 8'h01;
  localparam logic [BURST_N_W-1:0] BURST_N_MAX = 8'hFF;

  // optobias and soft-start pacing
  localparam int OPTO_STEP_DEFAULT = 5000;
  localparam logic [TMR_W-1:0] RAMP_STEP_CYC = 16'h01F4;

  // feedback and threshold codes
  localparam logic [DAC_W-1:0] FB_TARGET_UA = 10'h055;
  localparam logic [DAC_W-1:0] FB_BURST_UA = 10'h06A;
  localparam logic [DAC_W-1:0] FB_SPAN = 10'h0C8;
  localparam logic [DAC_W-1:0] OFFSET_MAX = 10'h1FF;
  localparam logic [DAC_W-1:0] CAP_MID = 10'h200;
  localparam logic [DAC_W-1:0] DELTA_MIN = 10'h020;
  localparam logic [DAC_W-1:0] DELTA_MAX = 10'h3FE;
  localparam logic [DAC_W-1:0] LP_HYST = 10'h010;

  typedef enum logic [1:0] {MODE_HP, MODE_LP, MODE_BURST} rhb_mode_t;
  typedef enum logic [2:0] {ST_OFF, ST_LS_ON, ST_DT_LH, ST_HS_ON, ST_DT_HL, ST_HOLD}
    rhb_state_t;
endpackage

/* File: rhb_sync.sv */
// Purpose: two-flop synchroniser for a group of independent comparator levels
// Assumes: each bit is a slow level; no bit-to-bit coherence is needed
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none
module rhb_sync #(
  parameter int W = 1
) (
  input wire logic clk, // core clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic [W-1:0] din, // asynchronous levels
  output logic [W-1:0] dout // synchronised levels
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: rhb_ctrl.sv */
// Purpose: switching and mode control of a resonant half-bridge regulated by cap thresholds
// Assumes: comparator inputs asynchronous; feedback code, settings synchronous and steady
// Notes: threshold outputs feed external DACs that set the cap comparator levels
// What this block does
// RQ1 - cap above upper: high off, then low on
// RQ2 - cap below lower: low off, then high on
// RQ3 - threshold gap set from measured feedback current
// RQ4 - falling feedback current widens both thresholds
// RQ5 - slowly regulate feedback current toward 85 uA
// RQ6 - soft start ramps gap from configured start value
// RQ7 - enter low-power below configurable entry level
// RQ8 - low-power: three halves then hold, gap boosted
// RQ9 - hold resumes exactly where switching paused
// RQ10 - shrink gap first, then lengthen hold
// RQ11 - stop at 23 kHz floor, then burst
// RQ12 - burst alternates low-power cycles and long hold
// RQ13 - burst rate selectable 200/400/800/1600 Hz
// RQ14 - burst-on starts when feedback below 106 uA
// RQ15 - measure burst period, keep it at least target
// RQ16 - period on target: keep same cycle count
// RQ17 - period short: raise cycle count next burst
// RQ18 - off holds low gate on; minimum on-time
// RQ19 - low-on ends: lower cap, overcurrent, capacitive, timeout
// RQ20 - dead time: min wait, then peak with current<=0
// RQ21 - no peak: proceed at max dead time
// RQ22 - high side mirrors low side criteria
// RQ23 - synchronise all comparator inputs first
// RQ24 - on and dead times as cycle counters
`timescale 1ns/1ns
`default_nettype none
module rhb_ctrl import rhb_pkg::*; #(
  parameter int BURST_BASE_CYCLES = BURST_200HZ_CYCLES,
  parameter int OPTO_STEP_CYCLES = OPTO_STEP_DEFAULT
) (
  input wire logic CORE_CLK, // system clock
  input wire logic SYS_RST, // asynchronous reset, active high
  input wire logic ENABLE, // run request; low keeps the bridge off
  input wire logic CAP_ABOVE_UPPER, // cap sense above upper threshold
  input wire logic CAP_BELOW_LOWER, // cap sense below lower threshold
  input wire logic BRIDGE_PEAK, // bridge midpoint node peak seen
  input wire logic CURRENT_NONPOS, // resonant current zero or negative
  input wire logic CURRENT_NONNEG, // resonant current zero or positive
  input wire logic OVERCURRENT_TRIP, // overcurrent comparator
  input wire logic NEAR_CAPACITIVE, // close to capacitive mode
  input wire logic [DAC_W-1:0] FEEDBACK_CURRENT_SENSE, // feedback current, uA
  input wire logic [DAC_W-1:0] START_DELTA, // soft-start gap setting
  input wire logic [DAC_W-1:0] LOW_POWER_ENTRY_LEVEL, // low-power entry demand
  input wire logic [1:0] BURST_FREQ_SEL, // 0..3 = 200/400/800/1600 Hz
  output logic LOW_SIDE_GATE, // low-side gate drive
  output logic HIGH_SIDE_GATE, // high-side gate drive
  output logic [DAC_W-1:0] UPPER_CAP_THRESHOLD, // upper threshold code
  output logic [DAC_W-1:0] LOWER_CAP_THRESHOLD, // lower threshold code
  output logic [1:0] MODE, // 0 high-power, 1 low-power, 2 burst
  output logic [BURST_N_W-1:0] BURST_COUNT // low-power cycles per burst-on
);
  // saturate an extended sum into the usable gap range
  function automatic logic [DAC_W-1:0] clamp_delta(input logic [DAC_W+1:0] v);
    clamp_delta = (v > {2'b00, DELTA_MAX}) ? DELTA_MAX : v[DAC_W-1:0];
  endfunction

  logic [SYNC_W-1:0] sync_q;
  logic c_upper, c_lower, c_peak, c_nonpos, c_nonneg, c_ocp, c_capm;

  rhb_sync #(.W(SYNC_W)) u_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .din({CAP_ABOVE_UPPER, CAP_BELOW_LOWER, BRIDGE_PEAK, CURRENT_NONPOS,
          CURRENT_NONNEG, OVERCURRENT_TRIP, NEAR_CAPACITIVE}), // RQ23
    .dout(sync_q)
  );
  assign {c_upper, c_lower, c_peak, c_nonpos, c_nonneg, c_ocp, c_capm} = sync_q;

  // power path state
  logic [DAC_W-1:0] offset, next_offset, ramp, next_ramp, upper, next_upper;
  logic [DAC_W-1:0] lower, next_lower;
  logic ramp_done, next_ramp_done;
  logic [TIMER_W-1:0] opto_tmr, next_opto_tmr;
  logic [TMR_W-1:0] ramp_tmr, next_ramp_tmr;
  logic [DAC_W-1:0] demand, lp_delta, target, delta;
  logic [DAC_W+1:0] lp_boost;
  logic deficit;

  // bridge state
  rhb_state_t state, next_state, resume, next_resume;
  rhb_mode_t mode, next_mode;
  logic ls, next_ls, hs, next_hs;
  logic [TMR_W-1:0] tmr, next_tmr;
  logic [1:0] half_cnt, next_half_cnt;
  logic [LP_W-1:0] lp_tmr, next_lp_tmr, act_len, next_act_len, hold_ext, next_hold_ext;
  logic [TIMER_W-1:0] burst_tmr, next_burst_tmr, burst_target;
  logic [BURST_N_W-1:0] burst_n, next_burst_n, burst_left, next_burst_left;
  logic [LP_W+1:0] lp_period;
  logic ls_end, hs_end, lh_go, hl_go, go_hold;

  assign burst_target = TIMER_W'(BURST_BASE_CYCLES) >> BURST_FREQ_SEL; // RQ13

  always_comb begin
    // lower feedback current means more demanded power; offset is the optobias term
    demand = clamp_delta({2'b00, (FEEDBACK_CURRENT_SENSE >= FB_SPAN) ? {DAC_W{1'b0}} :
                          FB_SPAN - FEEDBACK_CURRENT_SENSE} + {2'b00, offset}); // RQ3 RQ4
    // 1.5x gap makes up for the one-third hold in low power
    lp_boost = {2'b00, demand} + {3'b000, demand[DAC_W-1:1]}; // RQ8
    deficit = lp_boost < {2'b00, DELTA_MIN};
    lp_delta = deficit ? DELTA_MIN : clamp_delta(lp_boost); // RQ10
    target = (mode == MODE_HP) ? demand : lp_delta;
    delta = ramp_done ? target : ramp; // RQ6
    next_offset = offset;
    next_opto_tmr = opto_tmr + 1'b1;
    if (opto_tmr >= TIMER_W'(OPTO_STEP_CYCLES - 1)) begin
      next_opto_tmr = '0;
      // slow loop: too little current raises the power offset, too much lowers it
      if (FEEDBACK_CURRENT_SENSE < FB_TARGET_UA && offset < OFFSET_MAX) begin
        next_offset = offset + 1'b1; // RQ5
      end else if (FEEDBACK_CURRENT_SENSE > FB_TARGET_UA && offset != '0) begin
        next_offset = offset - 1'b1; // RQ5
      end
    end
    next_ramp = ramp;
    next_ramp_done = ramp_done;
    next_ramp_tmr = ramp_tmr + 1'b1;
    if (state == ST_OFF) begin
      next_ramp = START_DELTA; // RQ6
      next_ramp_done = 1'b0;
      next_ramp_tmr = '0;
    end else if (!ramp_done) begin
      if (ramp >= target) begin
        next_ramp_done = 1'b1;
      end else if (ramp_tmr >= RAMP_STEP_CYC - 1'b1) begin
        next_ramp_tmr = '0;
        next_ramp = ramp + 1'b1; // RQ6
      end
    end
    next_upper = CAP_MID + {1'b0, delta[DAC_W-1:1]}; // RQ4
    next_lower = CAP_MID - {1'b0, delta[DAC_W-1:1]}; // RQ4
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      offset <= '0;
      opto_tmr <= '0;
      ramp <= '0;
      ramp_done <= 1'b0;
      ramp_tmr <= '0;
      upper <= CAP_MID;
      lower <= CAP_MID;
    end else begin
      offset <= next_offset;
      opto_tmr <= next_opto_tmr;
      ramp <= next_ramp;
      ramp_done <= next_ramp_done;
      ramp_tmr <= next_ramp_tmr;
      upper <= next_upper;
      lower <= next_lower;
    end
  end

  always_comb begin
    // end of each on-state: minimum on-time first, maximum on-time always wins
    ls_end = (tmr >= TON_MIN_CYC && (c_lower || c_ocp || c_capm || !ENABLE))
             || tmr >= TON_MAX_CYC; // RQ19 RQ24
    hs_end = (tmr >= TON_MIN_CYC && (c_upper || c_ocp || c_capm || !ENABLE))
             || tmr >= TON_MAX_CYC; // RQ1 RQ22 RQ24
    // peak ignored before the minimum dead time to avoid false detection
    lh_go = tmr >= TNO_MIN_CYC && c_nonpos && (c_peak || tmr >= TNO_MAX_CYC); // RQ20 RQ21
    hl_go = tmr >= TNO_MIN_CYC && c_nonneg && (c_peak || tmr >= TNO_MAX_CYC); // RQ22
    lp_period = {2'b00, act_len} + {3'b000, act_len[LP_W-1:1]} + {2'b00, hold_ext};
    go_hold = mode != MODE_HP && half_cnt == LP_HALF_LAST; // RQ8
    next_state = state;
    next_resume = resume;
    next_mode = mode;
    next_ls = ls;
    next_hs = hs;
    next_tmr = (tmr == '1) ? tmr : tmr + 1'b1;
    next_half_cnt = half_cnt;
    next_lp_tmr = (lp_tmr == '1) ? lp_tmr : lp_tmr + 1'b1;
    next_act_len = act_len;
    next_hold_ext = hold_ext;
    next_burst_tmr = (burst_tmr == '1) ? burst_tmr : burst_tmr + 1'b1;
    next_burst_n = burst_n;
    next_burst_left = burst_left;
    case (state)
      ST_OFF: begin
        next_ls = 1'b1; // RQ18
        next_hs = 1'b0;
        next_mode = MODE_HP;
        next_half_cnt = '0;
        next_hold_ext = '0;
        next_tmr = '0;
        if (ENABLE) begin
          next_state = ST_LS_ON;
        end
      end
      ST_LS_ON: begin
        if (ls_end) begin
          next_ls = 1'b0; // RQ2
          next_tmr = '0;
          next_state = ST_DT_LH;
          if (!ENABLE) begin
            next_ls = 1'b1;
            next_state = ST_OFF;
          end else if (mode == MODE_HP && demand < LOW_POWER_ENTRY_LEVEL) begin
            next_mode = MODE_LP; // RQ7
            next_half_cnt = '0;
            next_lp_tmr = '0;
          end else if (go_hold) begin
            next_resume = ST_DT_LH; // RQ9
            next_state = ST_HOLD;
          end
          if (mode != MODE_HP) begin
            next_half_cnt = go_hold ? 2'b00 : half_cnt + 1'b1;
          end
        end
      end
      ST_DT_LH: begin
        if (lh_go) begin
          next_hs = 1'b1; // RQ2
          next_tmr = '0;
          next_state = ST_HS_ON;
        end
      end
      ST_HS_ON: begin
        if (hs_end) begin
          next_hs = 1'b0; // RQ1
          next_tmr = '0;
          next_state = ST_DT_HL;
          if (go_hold) begin
            next_resume = ST_DT_HL; // RQ9
            next_state = ST_HOLD;
          end
          if (mode != MODE_HP) begin
            next_half_cnt = go_hold ? 2'b00 : half_cnt + 1'b1;
          end
        end
      end
      ST_DT_HL: begin
        if (hl_go) begin
          next_ls = 1'b1; // RQ1
          next_tmr = '0;
          next_state = ST_LS_ON;
        end
      end
      default: begin // ST_HOLD
        if (state != resume && lp_tmr == '0) begin
          next_state = resume;
        end
        next_tmr = '0;
        if (!ENABLE) begin
          next_ls = 1'b1;
          next_state = ST_OFF;
        end else if (next_resume == resume && state == ST_HOLD) begin
          if (mode == MODE_BURST && burst_left == '0) begin
            // extended hold; a demand rise starts the next burst-on at once
            if (FEEDBACK_CURRENT_SENSE < FB_BURST_UA) begin // RQ14
              if (burst_tmr < burst_target && burst_n != BURST_N_MAX) begin
                next_burst_n = burst_n + 1'b1; // RQ15 RQ17
              end // RQ16: on or past target the count stays
              next_burst_left = (burst_tmr < burst_target && burst_n != BURST_N_MAX) ?
                                burst_n + 1'b1 : burst_n;
              next_burst_tmr = '0; // RQ15
              next_lp_tmr = '0;
              next_state = resume; // RQ12
              if (!deficit) begin
                next_mode = MODE_LP;
              end
            end
          end else if ({2'b00, lp_tmr} >= lp_period || lp_tmr >= LP_PERIOD_MAX_CYC) begin
            next_lp_tmr = '0;
            next_state = resume; // RQ9
          end
        end
      end
    endcase
    // bookkeeping at the moment a hold starts
    if (next_state == ST_HOLD && state != ST_HOLD) begin
      next_act_len = lp_tmr;
      if ({1'b0, demand} >= {1'b0, LOW_POWER_ENTRY_LEVEL} + {1'b0, LP_HYST}) begin
        next_mode = MODE_HP;
        next_state = resume == ST_DT_LH ? ST_DT_LH : ST_DT_HL;
        next_state = next_resume;
      end else if (mode == MODE_BURST) begin
        next_burst_left = (burst_left == '0) ? '0 : burst_left - 1'b1; // RQ12
      end else if (deficit) begin
        // gap already at minimum: stretch hold until the 23 kHz floor
        if (lp_period + {2'b00, HOLD_STEP} <= {2'b00, LP_PERIOD_MAX_CYC}) begin
          next_hold_ext = hold_ext + HOLD_STEP; // RQ10
        end else begin
          next_mode = MODE_BURST; // RQ11
          next_burst_n = BURST_N_INIT;
          next_burst_left = '0;
        end
      end else if (hold_ext >= HOLD_STEP) begin
        next_hold_ext = hold_ext - HOLD_STEP; // RQ10
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= ST_OFF;
      resume <= ST_DT_LH;
      mode <= MODE_HP;
      ls <= 1'b1; // RQ18
      hs <= 1'b0;
      tmr <= '0;
      half_cnt <= '0;
      lp_tmr <= '0;
      act_len <= '0;
      hold_ext <= '0;
      burst_tmr <= '0;
      burst_n <= BURST_N_INIT;
      burst_left <= '0;
    end else begin
      state <= next_state;
      resume <= next_resume;
      mode <= next_mode;
      ls <= next_ls;
      hs <= next_hs;
      tmr <= next_tmr;
      half_cnt <= next_half_cnt;
      lp_tmr <= next_lp_tmr;
      act_len <= next_act_len;
      hold_ext <= next_hold_ext;
      burst_tmr <= next_burst_tmr;
      burst_n <= next_burst_n;
      burst_left <= next_burst_left;
    end
  end

  assign LOW_SIDE_GATE = ls;
  assign HIGH_SIDE_GATE = hs;
  assign UPPER_CAP_THRESHOLD = upper;
  assign LOWER_CAP_THRESHOLD = lower;
  assign MODE = mode;
  assign BURST_COUNT = burst_n;
endmodule
`default_nettype wire

/* File: rhb_tank_model.sv */
// Purpose: behavioural half-bridge tank and sense comparators facing rhb_ctrl
// Assumes: comparator levels change just after a clock edge
// Notes: stall keeps the cap comparators quiet, no_peak hides the midpoint peak
`timescale 1ns/1ns
`default_nettype none
module rhb_tank_model #(
  parameter int ON_CYC = 55,
  parameter int PEAK_CYC = 20
) (
  input wire logic clk, // core clock
  input wire logic rst, // reset
  input wire logic ls, // low gate
  input wire logic hs, // high gate
  input wire logic stall, // never reach a threshold
  input wire logic no_peak, // never show a peak
  output logic cap_above, // cap above upper
  output logic cap_below, // cap below lower
  output logic peak, // midpoint peak
  output logic cur_nonpos, // current <= 0
  output logic cur_nonneg // current >= 0
);
  int cnt;
  logic [1:0] prev;
  logic last_ls;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      prev <= 2'h2;
      last_ls <= 1'b1;
    end else begin
      cnt <= (prev != {ls, hs}) ? 0 : cnt + 1;
      prev <= {ls, hs};
      if (ls)
        last_ls <= 1'b1;
      else if (hs)
        last_ls <= 1'b0;
    end
  end
  assign cap_below = ls && !stall && cnt >= ON_CYC;
  assign cap_above = hs && !stall && cnt >= ON_CYC;
  assign peak = !ls && !hs && !no_peak && cnt >= PEAK_CYC;
  // tank current keeps the sign of the last pulse through dead time and hold
  assign cur_nonpos = last_ls;
  assign cur_nonneg = !last_ls;
endmodule
`default_nettype wire

/* File: rhb_ctrl_sva.sv */
// Purpose: gate timing and threshold checks on the rhb_ctrl ports
// Assumes: one clock domain, async active-high reset
// Notes: counts saturate so a long off state cannot wrap
`timescale 1ns/1ns
`default_nettype none
module rhb_ctrl_sva import rhb_pkg::*; (
  input wire logic CORE_CLK, // clock
  input wire logic SYS_RST, // reset
  input wire logic ENABLE, // run
  input wire logic CAP_ABOVE_UPPER, // cap high
  input wire logic CAP_BELOW_LOWER, // cap low
  input wire logic CURRENT_NONPOS, // current <= 0
  input wire logic CURRENT_NONNEG, // current >= 0
  input wire logic LOW_SIDE_GATE, // low gate
  input wire logic HIGH_SIDE_GATE, // high gate
  input wire logic [DAC_W-1:0] UPPER_CAP_THRESHOLD, // upper code
  input wire logic [DAC_W-1:0] LOWER_CAP_THRESHOLD, // lower code
  input wire logic [BURST_N_W-1:0] BURST_COUNT // cycles per burst
);
  logic [TMR_W-1:0] ls_cnt, hs_cnt, dead_cnt, next_ls_cnt, next_hs_cnt, next_dead_cnt;
  logic both_off;
  always_comb begin
    both_off = !LOW_SIDE_GATE && !HIGH_SIDE_GATE;
    next_ls_cnt = LOW_SIDE_GATE ? ls_cnt + {15'h0000, ~&ls_cnt} : 16'h0000;
    next_hs_cnt = HIGH_SIDE_GATE ? hs_cnt + {15'h0000, ~&hs_cnt} : 16'h0000;
    next_dead_cnt = both_off ? dead_cnt + {15'h0000, ~&dead_cnt} : 16'h0000;
  end
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ls_cnt <= 16'h0000;
      hs_cnt <= 16'h0000;
      dead_cnt <= 16'h0000;
    end else begin
      ls_cnt <= next_ls_cnt;
      hs_cnt <= next_hs_cnt;
      dead_cnt <= next_dead_cnt;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_low_due;
    ENABLE && CAP_BELOW_LOWER && LOW_SIDE_GATE && ls_cnt > TON_MIN_CYC;
  endsequence
  sequence s_high_due;
    ENABLE && CAP_ABOVE_UPPER && HIGH_SIDE_GATE && hs_cnt > TON_MIN_CYC;
  endsequence
  a_gates_exclusive: assert property (!(LOW_SIDE_GATE && HIGH_SIDE_GATE))
    else $error("both gates on");
  a_low_min_on: assert property ($fell(LOW_SIDE_GATE) |-> ls_cnt >= TON_MIN_CYC)
    else $error("low gate shorter than min on");
  a_high_min_on: assert property ($fell(HIGH_SIDE_GATE) && ENABLE |-> hs_cnt >= TON_MIN_CYC)
    else $error("high gate shorter than min on");
  a_high_max_on: assert property (hs_cnt <= TON_MAX_CYC + 16'h0004)
    else $error("high gate past max on");
  a_dead_before_high: assert property ($rose(HIGH_SIDE_GATE) |-> dead_cnt >= TNO_MIN_CYC)
    else $error("short dead time before high");
  a_dead_before_low: assert property ($rose(LOW_SIDE_GATE) && ENABLE |-> dead_cnt >= TNO_MIN_CYC)
    else $error("short dead time before low");
  a_high_cur_sign: assert property ($rose(HIGH_SIDE_GATE) |-> $past(CURRENT_NONPOS, 3))
    else $error("high on with positive current");
  a_low_cur_sign: assert property ($rose(LOW_SIDE_GATE) && ENABLE |-> $past(CURRENT_NONNEG, 3))
    else $error("low on with negative current");
  a_low_ends_cap: assert property (s_low_due |-> ##[0:60] !LOW_SIDE_GATE)
    else $error("low gate ignores lower threshold");
  a_high_ends_cap: assert property (s_high_due |-> ##[0:60] !HIGH_SIDE_GATE)
    else $error("high gate ignores upper threshold");
  // a high-side pulse in flight still finishes; once the low gate is on it stays on
  a_off_low_on: assert property (!ENABLE && LOW_SIDE_GATE |=> LOW_SIDE_GATE && !HIGH_SIDE_GATE)
    else $error("off state gates wrong");
  a_thr_symmetric: assert property ({1'b0, UPPER_CAP_THRESHOLD} + {1'b0, LOWER_CAP_THRESHOLD}
    == 11'h400 && UPPER_CAP_THRESHOLD >= LOWER_CAP_THRESHOLD)
    else $error("thresholds not centred");
  a_burst_step: assert property (BURST_COUNT == $past(BURST_COUNT)
    || BURST_COUNT == $past(BURST_COUNT) + 8'h01)
    else $error("burst count jumped");
endmodule
bind rhb_ctrl rhb_ctrl_sva rhb_ctrl_sva_i (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .ENABLE(ENABLE),
  .CAP_ABOVE_UPPER(CAP_ABOVE_UPPER), .CAP_BELOW_LOWER(CAP_BELOW_LOWER),
  .CURRENT_NONPOS(CURRENT_NONPOS), .CURRENT_NONNEG(CURRENT_NONNEG),
  .LOW_SIDE_GATE(LOW_SIDE_GATE), .HIGH_SIDE_GATE(HIGH_SIDE_GATE),
  .UPPER_CAP_THRESHOLD(UPPER_CAP_THRESHOLD), .LOWER_CAP_THRESHOLD(LOWER_CAP_THRESHOLD),
  .BURST_COUNT(BURST_COUNT));
`default_nettype wire

/* File: rhb_ctrl_tb.sv */
// Purpose: self-checking bench for rhb_ctrl against a behavioural tank
// Assumes: short burst and optobias pacing parameters
// Notes: burst entry takes too long to reach here; its count is watched by the checker
`timescale 1ns/1ns
`default_nettype none
module rhb_ctrl_tb import rhb_pkg::*;;
  logic clk, rst, enable, oc_trip, near_cap, stall, no_peak;
  logic cap_above, cap_below, peak, cur_nonpos, cur_nonneg, ls, hs;
  logic [DAC_W-1:0] fb, start_delta, lp_entry, upper, lower;
  logic [1:0] mode;
  logic [BURST_N_W-1:0] burst_count;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  rhb_ctrl #(.BURST_BASE_CYCLES(2000), .OPTO_STEP_CYCLES(20)) rhb_ctrl_i (.CORE_CLK(clk),
    .SYS_RST(rst), .ENABLE(enable), .CAP_ABOVE_UPPER(cap_above), .CAP_BELOW_LOWER(cap_below),
    .BRIDGE_PEAK(peak), .CURRENT_NONPOS(cur_nonpos), .CURRENT_NONNEG(cur_nonneg),
    .OVERCURRENT_TRIP(oc_trip), .NEAR_CAPACITIVE(near_cap), .FEEDBACK_CURRENT_SENSE(fb),
    .START_DELTA(start_delta), .LOW_POWER_ENTRY_LEVEL(lp_entry), .BURST_FREQ_SEL(2'h0),
    .LOW_SIDE_GATE(ls), .HIGH_SIDE_GATE(hs), .UPPER_CAP_THRESHOLD(upper),
    .LOWER_CAP_THRESHOLD(lower), .MODE(mode), .BURST_COUNT(burst_count));
  rhb_tank_model rhb_tank_model_i (.clk(clk), .rst(rst), .ls(ls), .hs(hs), .stall(stall),
    .no_peak(no_peak), .cap_above(cap_above), .cap_below(cap_below), .peak(peak),
    .cur_nonpos(cur_nonpos), .cur_nonneg(cur_nonneg));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  function automatic logic [DAC_W-1:0] gap();
    return upper - lower;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // sel 0 watches the low gate, 1 the high gate; n returns the cycles waited
  task automatic wait_gate(input int sel, input logic val, input int lim, output int n);
    n = 0;
    while (((sel == 0) ? ls : hs) !== val && n < lim) begin
      @(posedge clk);
      n++;
    end
    check("gate wait", 32'(n < lim), 1);
  endtask
  task automatic do_reset(input logic [DAC_W-1:0] sd);
    rst <= 1'b1;
    enable <= 1'b0;
    start_delta <= sd;
    tick(5);
    rst <= 1'b0;
    tick(1);
    enable <= 1'b1;
  endtask
  // hold is far longer than any dead time, so 80 idle cycles mark it
  task automatic scan_halves(output int ph);
    int n;
    int k;
    logic on;
    ph = 0;
    n = 0;
    k = 0;
    on = 1'b0;
    while ((n < 80 || ph == 0) && k < 6000) begin
      @(posedge clk);
      k++;
      if ((ls | hs) && !on)
        ph++;
      on = ls | hs;
      n = on ? 0 : n + 1;
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    int n;
    int k;
    logic [DAC_W-1:0] g1, g2, g3;
    rst = 1'b1;
    enable = 1'b0;
    oc_trip = 1'b0;
    near_cap = 1'b0;
    stall = 1'b0;
    no_peak = 1'b0;
    fb = 10'h000;
    start_delta = 10'h040;
    lp_entry = 10'h000;
    tick(3);
    check("reset gates mode count", {ls, hs, mode, burst_count}, {4'h8, 8'h01});
    check("reset thresholds", {upper, lower}, {10'h200, 10'h200});
    do_reset(10'h040);
    tick(100);
    g1 = gap();
    tick(1500);
    check("start gap low", 32'(g1 < 10'h048), 1);
    check("start gap rises", 32'(gap() > g1), 1);
    wait_gate(0, 1, 2000, n);
    wait_gate(0, 0, 2000, n);
    wait_gate(1, 1, 200, n);
    check("dead low to high", 32'(n >= 10 && n <= 60), 1);
    wait_gate(1, 0, 2000, n);
    wait_gate(0, 1, 200, n);
    check("dead high to low", 32'(n >= 10 && n <= 60), 1);
    $display("test soft start and switching done");
    do_reset(10'h3FE);
    fb <= 10'd100;
    tick(1500);
    g1 = gap();
    fb <= 10'd60;
    tick(30);
    g2 = gap();
    check("gap after load step", 32'(g2 > g1), 1);
    tick(1500);
    g3 = gap();
    check("gap while feedback low", 32'(g3 > g2), 1);
    fb <= 10'd120;
    tick(1500);
    check("gap while feedback high", 32'(gap() < g3), 1);
    $display("test regulation done");
    stall <= 1'b1;
    wait_gate(0, 0, 3000, n);
    wait_gate(0, 1, 3000, n);
    wait_gate(0, 0, 1400, n);
    check("low max on", 32'(n >= 1250 && n <= 1256), 1);
    wait_gate(1, 1, 200, n);
    wait_gate(1, 0, 1400, n);
    check("high max on", 32'(n >= 1250 && n <= 1256), 1);
    for (k = 0; k < 2; k++) begin
      wait_gate(0, 1, 3000, n);
      tick(100);
      if (k == 0)
        oc_trip <= 1'b1;
      else
        near_cap <= 1'b1;
      wait_gate(0, 0, 1400, n);
      check("trip ends low", 32'(n <= 5), 1);
      oc_trip <= 1'b0;
      near_cap <= 1'b0;
    end
    no_peak <= 1'b1;
    wait_gate(1, 1, 200, n);
    wait_gate(1, 0, 1400, n);
    wait_gate(0, 1, 200, n);
    check("dead without peak", 32'(n >= 50 && n <= 56), 1);
    enable <= 1'b0;
    tick(4);
    check("off gates", {ls, hs}, 2'h2);
    stall <= 1'b0;
    no_peak <= 1'b0;
    $display("test protections done");
    do_reset(10'h3FE);
    fb <= 10'd85;
    tick(300);
    g1 = gap();
    lp_entry <= 10'h3FF;
    k = 0;
    while (mode !== 2'h1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    check("enter low power", mode, 2'h1);
    tick(200);
    check("low power gap boost", 32'(gap() > g1), 1);
    scan_halves(n);
    scan_halves(n);
    check("halves per hold", n, 3);
    $display("test low power done");
    give_verdict();
  end
endmodule
`default_nettype wire
